// ==== rtl/prd_pkg.sv ====
// Purpose: constants and carriers for the strap ratio decoder
// Assumes: config word bit 0 is the leftmost, fields read msb first
// Notes: register offsets are byte addresses on a 32-bit bus
package prd_pkg;
  localparam int CFG_W = 256; // config word width
  localparam int MEM_RAT_POS = 10; // memory ratio code, 5 bits
  localparam int MEM_RNG_POS = 16; // memory pll range code, 2 bits
  localparam int SYNC_POS = 184; // memory sync-select bit
  localparam int RATE_POS = 232; // memory rate-select bit
  localparam int SPARE_POS = 234; // memory spare bit
  localparam int LANE_RAT_POS = 128; // four 3-bit lane ratio codes
  localparam int B1_HALVE_POS = 144; // five bank 1 halve bits
  localparam int BN_HALVE_POS = 149; // halve bits of banks 2..4
  localparam logic [4:0] SYNC_CODE = 5'h01; // only sync ratio code
  localparam logic [4:0] MULT_NONE = 5'h00; // reserved ratio
  localparam logic [7:0] REG_MEM = 8'h00; // memory settings, ro
  localparam logic [7:0] REG_LANE = 8'h04; // lane multipliers, ro
  localparam logic [7:0] REG_HALVE = 8'h08; // lane halve bits, ro
  localparam logic [7:0] REG_ERR = 8'h0c; // sticky errors, w1c
  localparam logic [7:0] REG_MODE = 8'h10; // raw mode bits, ro

  typedef struct packed {
    logic sync; // synchronous memory clocking
    logic ref_plat; // 1: reference is platform clock
    logic bus_half; // bus clock is platform/2
    logic [4:0] mult; // data rate multiplier, 0 = reserved
    logic [1:0] range; // memory pll range code
  } prd_mem_cfg_t;

  typedef struct packed {
    logic [3:0][5:0] mult; // per-bank multiplier, 0 = reserved
    logic [4:0] b1_halve; // bank 1 lane pair halve bits
    logic [2:0] bn_halve; // banks 2..4 halve bits
  } prd_lane_cfg_t;

  typedef struct packed {
    logic mode; // sync and rate bits disagree
    logic ratio; // reserved memory ratio code
    logic [3:0] lane; // reserved lane code per bank
  } prd_err_t;
endpackage

// ==== rtl/prd_decode.sv ====
// Purpose: capture the reset config word and decode pll settings
// Assumes: word arrives on pins, stable while reset is low
// Notes: clock pins of the plls are not used here, only selected
`timescale 1ns/1ns
module prd_decode #(
  parameter int CFG_W = prd_pkg::CFG_W // config word width
) (
  input wire logic clock, // 125 MHz block clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state
  input wire logic [0:CFG_W-1] reset_config_word, // strap pins
  input wire logic [7:0] address, // avalon byte address
  input wire logic read, // avalon read
  input wire logic write, // avalon write
  input wire logic [31:0] writedata, // avalon write data
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon wait
  output logic cfg_valid, // settings decoded and stable
  output prd_pkg::prd_mem_cfg_t mem_ctrl0_cfg, // memory controller 0
  output prd_pkg::prd_mem_cfg_t mem_ctrl1_cfg, // memory controller 1
  output prd_pkg::prd_lane_cfg_t lane_cfg, // serial lane plls
  output logic cfg_error // any sticky error bit set
);
  ////////////////////////////////////////////////////////////////
  // pin synchroniser and one-shot capture
  logic [0:CFG_W-1] sync1_q, sync2_q, sync3_q; // three-stage sync
  logic [0:CFG_W-1] word_q; // captured word
  logic taken_q; // word has been captured
  logic valid_q; // decoded outputs loaded
  logic [2:0] fill_q; // marks stages that hold a sample taken after reset

  // straps are pins, so they pass the usual three stages
  // the word only moves at power-up, so the latency costs nothing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (ce) begin
      sync1_q <= reset_config_word;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // the stages reset to zero, and two zero stages would pass for an
  // agreed word; a marker bit travels beside the samples so capture
  // waits until the third stage holds a pin value taken after reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fill_q <= 3'h0;
    end else if (ce) begin
      fill_q <= {fill_q[1:0], 1'b1};
    end
  end

  // capture once stages agree; never again until reset
  // later pin movement is ignored, so a strap glitch after boot
  // cannot retune a running pll
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      word_q <= '0;
      taken_q <= 1'b0;
    end else if (ce && !taken_q && fill_q[2] && sync2_q == sync3_q) begin
      word_q <= sync3_q;
      taken_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // decode of the captured word
  prd_pkg::prd_mem_cfg_t mem_d, mem_q; // memory settings
  prd_pkg::prd_lane_cfg_t lane_d, lane_q; // lane settings
  prd_pkg::prd_err_t err_d; // errors of the captured word
  logic [4:0] rat_code; // memory ratio code
  logic [3:0][2:0] lane_code; // lane ratio code per bank
  logic sync_bit, rate_bit; // mode bits

  assign rat_code = word_q[prd_pkg::MEM_RAT_POS +: 5];
  assign sync_bit = word_q[prd_pkg::SYNC_POS];
  assign rate_bit = word_q[prd_pkg::RATE_POS];

  // memory side: one decode feeds both controllers
  // a reserved code decodes to a zero multiplier, which the error
  // terms below reuse
  always_comb begin
    mem_d.sync = sync_bit;
    mem_d.ref_plat = sync_bit;
    mem_d.bus_half = sync_bit;
    mem_d.range = word_q[prd_pkg::MEM_RNG_POS +: 2];
    mem_d.mult = prd_pkg::MULT_NONE;
    if (sync_bit) begin
      if (rat_code == prd_pkg::SYNC_CODE) begin
        mem_d.mult = 5'h01;
      end
    end else begin
      case (rat_code)
        5'h05: mem_d.mult = 5'h05;
        5'h06: mem_d.mult = 5'h06;
        5'h08: mem_d.mult = 5'h08;
        5'h09: mem_d.mult = 5'h09;
        5'h0a: mem_d.mult = 5'h0a;
        5'h0c: mem_d.mult = 5'h0c;
        5'h0d: mem_d.mult = 5'h0d;
        5'h10: mem_d.mult = 5'h10;
        5'h12: mem_d.mult = 5'h12;
        5'h13: mem_d.mult = 5'h13;
        5'h14: mem_d.mult = 5'h14;
        5'h18: mem_d.mult = 5'h18;
        default: mem_d.mult = prd_pkg::MULT_NONE; // reserved
      endcase
    end
  end

  // lane side: code meaning depends on the bank
  // the bank index takes part in every arm but the default, since a code legal on
  // one bank may be reserved on the next
  always_comb begin
    lane_d.b1_halve = word_q[prd_pkg::B1_HALVE_POS +: 5];
    lane_d.bn_halve = word_q[prd_pkg::BN_HALVE_POS +: 3];
    for (int b = 0; b < 4; b++) begin
      lane_code[b] = word_q[prd_pkg::LANE_RAT_POS + 3*b +: 3];
      lane_d.mult[b] = 6'h00;
      case (lane_code[b])
        3'h1: lane_d.mult[b] = (b == 1 || b == 2) ? 6'h14 : 6'h00;
        3'h2: lane_d.mult[b] = (b < 3) ? 6'h19 : 6'h00;
        3'h3: lane_d.mult[b] = (b < 3) ? 6'h28 : 6'h00;
        3'h4: lane_d.mult[b] = (b < 3) ? 6'h32 : 6'h00;
        3'h5: lane_d.mult[b] = (b >= 2) ? 6'h18 : 6'h00;
        3'h6: lane_d.mult[b] = (b >= 2) ? 6'h1e : 6'h00;
        default: lane_d.mult[b] = 6'h00; // 000 and 111 reserved
      endcase
    end
  end

  // error terms follow from the decode: zero means reserved
  always_comb begin
    err_d.mode = sync_bit ^ rate_bit;
    err_d.ratio = (mem_d.mult == prd_pkg::MULT_NONE);
    for (int b = 0; b < 4; b++) begin
      err_d.lane[b] = (lane_d.mult[b] == 6'h00);
    end
  end

  ////////////////////////////////////////////////////////////////
  // output registers, loaded once the word is held
  // loading once keeps the pll settings still while the plls lock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_q <= '0;
      lane_q <= '0;
      valid_q <= 1'b0;
    end else if (ce && taken_q && !valid_q) begin
      mem_q <= mem_d;
      lane_q <= lane_d;
      valid_q <= 1'b1;
    end
  end

  // the controllers must never see different settings
  // one register feeds both ports, so they cannot drift apart
  assign mem_ctrl0_cfg = mem_q;
  assign mem_ctrl1_cfg = mem_q;
  assign lane_cfg = lane_q;
  assign cfg_valid = valid_q;

  ////////////////////////////////////////////////////////////////
  // sticky errors, set at load, cleared by writing ones
  prd_pkg::prd_err_t err_q; // sticky error bits
  logic load_ev; // one-cycle decode load event
  logic ack_q; // bus access answered this cycle
  logic err_clr; // write to the error register
  logic [5:0] clr_bits; // bits that software clears

  assign load_ev = taken_q && !valid_q;
  assign err_clr = ack_q && write && address == prd_pkg::REG_ERR;
  assign clr_bits = err_clr ? writedata[5:0] : 6'h00;

  // a set in the clear cycle wins, so no event is lost
  // errors latch only at the load event; nothing sets them later
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      err_q <= '0;
    end else if (ce) begin
      err_q <= (err_q & ~clr_bits) | (load_ev ? err_d : '0);
    end
  end

  assign cfg_error = |err_q;

  ////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer
  logic [31:0] rdata_q; // read data, stands while ack_q is high

  // hold off the first cycle of every access to register data
  // every access costs two cycles; the fixed wait keeps the read
  // mux off the path from the bus pins
  assign waitrequest = (read || write) && !ack_q;
  assign readdata = rdata_q;

  // ack_q marks the answer cycle, so a held request is not taken twice
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= (read || write) && !ack_q;
    end
  end

  // unmapped addresses read as zero, writes there are dropped
  // read data are loaded in the wait cycle and stand until the next read
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce && read && !ack_q) begin
      case (address)
        prd_pkg::REG_MEM: rdata_q <= {22'h0, mem_q};
        prd_pkg::REG_LANE: rdata_q <= {8'h00, lane_q.mult};
        prd_pkg::REG_HALVE: rdata_q <= {24'h0, lane_q.bn_halve,
                                        lane_q.b1_halve};
        prd_pkg::REG_ERR: rdata_q <= {26'h0, err_q};
        prd_pkg::REG_MODE: rdata_q <= {29'h0,
                                       word_q[prd_pkg::SPARE_POS],
                                       rate_bit, sync_bit};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  // they watch flops and decode terms of this module only, so a fault
  // shows at the edge where it happens rather than later at the bus
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // memory controller settings
  ctrl_same_a: assert property (mem_ctrl0_cfg == mem_ctrl1_cfg)
    else $error("controllers differ");

  ref_select_a: assert property (valid_q |->
    mem_q.ref_plat == word_q[prd_pkg::SYNC_POS])
    else $error("memory reference select wrong");

  bus_half_a: assert property (valid_q |->
    mem_q.bus_half == word_q[prd_pkg::SYNC_POS])
    else $error("memory bus clock select wrong");

  async_mult_a: assert property (load_ev && ce && !sync_bit &&
    rat_code == 5'h13 |=> mem_q.mult == 5'h13 && !err_q.ratio)
    else $error("async ratio 19 misdecoded");

  sync_only_a: assert property (load_ev && ce && sync_bit &&
    rat_code != prd_pkg::SYNC_CODE |=> err_q.ratio && mem_q.mult == 0)
    else $error("sync reserved code accepted");

  // serial lane settings
  lane_b1_a: assert property (load_ev && ce &&
    lane_code[0] == 3'h1 |=> err_q.lane[0] && lane_q.mult[0] == 0)
    else $error("bank 1 code 001 accepted");

  lane_b2_a: assert property (load_ev && ce &&
    lane_code[1] == 3'h1 |=> lane_q.mult[1] == 6'h14 && !err_q.lane[1])
    else $error("bank 2 code 001 misdecoded");

  lane_rsv_a: assert property (load_ev && ce &&
    lane_code[1] == 3'h5 |=> err_q.lane[1] && lane_q.mult[1] == 0)
    else $error("bank 2 code 101 accepted");

  lane_b4_a: assert property (load_ev && ce &&
    lane_code[3] == 3'h6 |=> lane_q.mult[3] == 6'h1e)
    else $error("bank 4 code 110 misdecoded");

  halve_map_a: assert property (valid_q |->
    lane_q.b1_halve == word_q[prd_pkg::B1_HALVE_POS +: 5])
    else $error("bank 1 halve bits wrong");

  bn_halve_a: assert property (valid_q |->
    lane_q.bn_halve == word_q[prd_pkg::BN_HALVE_POS +: 3])
    else $error("bank 2 to 4 halve bits wrong");

  // capture and hold; the held word keeps every decode output quiet
  capture_wait_a: assert property (!taken_q && !fill_q[2] |=>
    !taken_q)
    else $error("word taken before stages filled");

  word_hold_a: assert property (taken_q |=> $stable(word_q))
    else $error("captured word changed");

  valid_hold_a: assert property (cfg_valid |=> cfg_valid)
    else $error("settings valid dropped");

  out_hold_a: assert property (valid_q |=>
    $stable(mem_q) && $stable(lane_q))
    else $error("settings changed after load");

  // errors and bus
  mode_err_a: assert property (load_ev && ce &&
    (sync_bit != rate_bit) |=> err_q.mode [*2])
    else $error("mode mismatch not flagged");

  err_set_a: assert property (load_ev && ce |=>
    (err_q & $past(err_d)) == $past(err_d))
    else $error("error bit lost at load");

  bus_wait_a: assert property ((read || write) && !ack_q && ce |=>
    !waitrequest)
    else $error("bus answer late");
endmodule

// ==== verif/prd_word_src.sv ====
// Purpose: strap source model that builds the reset config word
// Assumes: reference clock fixed by REF_KHZ
// Notes: unused bits toggle so a misplaced field shows up
`timescale 1ns/1ns
module prd_word_src #(
  parameter int REF_KHZ = 125000, // ref clock kHz, 161200 max at 6x
  parameter int PLAT_KHZ = 750000, // platform clock kHz
  parameter int LINK_W = 4 // trained link width, not the strap
) (
  input wire logic sync, // synchronous memory clocking wanted
  input wire logic bad, // breaks the rate bit on purpose
  input wire logic [4:0] rat, // memory_ratio_code
  input wire logic [11:0] lanes, // lane codes, bank 1 on top
  input wire logic [7:0] halves, // bank 1 five bits, then banks 2..4
  output logic [0:prd_pkg::CFG_W-1] word, // reset_config_word pins
  output logic plat_ok // platform clock meets the gen1 link minimum
);
  // gen1 links need the platform at 527 MHz x width / 16 or more
  assign plat_ok = PLAT_KHZ * 16 >= 527000 * LINK_W;
  logic [1:0] rng; // range code the board straps
  //////////////////////////////////////////////////////////////////////
  // range code follows the platform clock in sync mode, else ratio and reference clock
  always_comb begin
    if (sync) rng = (PLAT_KHZ > 600000) ? 2'h1 : 2'h3;
    else if (rat == 5'h08) rng = (REF_KHZ < 120900) ? 2'h2 : 2'h1;
    else if (rat == 5'h09) rng = (REF_KHZ < 107400) ? 2'h2 : 2'h1;
    else if (rat == 5'h0a) rng = 2'h1;
    else rng = 2'h3;
  end
  //////////////////////////////////////////////////////////////////////
  // fields laid over a toggling background
  always_comb begin
    word = {64{4'ha}};
    word[prd_pkg::MEM_RAT_POS +: 5] = rat;
    word[prd_pkg::MEM_RNG_POS +: 2] = rng;
    word[prd_pkg::SYNC_POS] = sync;
    word[prd_pkg::RATE_POS] = sync ^ bad;
    word[prd_pkg::SPARE_POS] = 1'b0;
    word[prd_pkg::LANE_RAT_POS +: 12] = lanes;
    word[prd_pkg::B1_HALVE_POS +: 8] = halves;
  end
endmodule

// ==== verif/prd_decode_tb_top.sv ====
// Purpose: self-checking bench for the strap ratio decoder
// Assumes: 125 MHz clock, reference clock 125 MHz in the model
// Notes: every row and sweep case re-runs reset so the word is captured again
`timescale 1ns/1ns
module prd_decode_tb_top;
  typedef struct packed {
    logic s; // sync mode
    logic b; // rate bit broken
    logic [4:0] rat; // ratio code
    logic [11:0] ln; // lane codes
    logic [7:0] hv; // halve bits
    logic [23:0] mu; // expected lane multipliers
    logic [3:0] le; // expected lane errors
  } prd_row_t;
  logic clock, rst_n, ce, read, write, waitrequest, cfg_valid, cfg_error;
  logic s, b, plat_ok;
  logic [4:0] rat;
  logic [11:0] ln;
  logic [7:0] hv, address;
  logic [31:0] writedata, readdata, q;
  logic [0:prd_pkg::CFG_W-1] word;
  logic [7:0] adr [5];
  prd_pkg::prd_mem_cfg_t mem0, mem1;
  prd_pkg::prd_lane_cfg_t lane;
  prd_row_t rw;
  int err_total, checked, i;
  prd_row_t rows [7] = '{
    '{1'b0, 1'b0, 5'h05, 12'h46e, 8'h00, {6'h1e,6'h18,6'h14,6'h19}, 4'h0},
    '{1'b0, 1'b0, 5'h08, 12'h6f5, 8'ha5, {6'h18,6'h1e,6'h28,6'h28}, 4'h0},
    '{1'b0, 1'b0, 5'h18, 12'h920, 8'h5a, {6'h00,6'h32,6'h32,6'h32}, 4'h8},
    '{1'b1, 1'b0, 5'h01, 12'h37b, 8'h81, 24'h0, 4'hf},
    '{1'b1, 1'b0, 5'h05, 12'h46e, 8'h7e, {6'h1e,6'h18,6'h14,6'h19}, 4'h0},
    '{1'b0, 1'b0, 5'h09, 12'h18f, 8'h3c, {6'h00,6'h14,6'h00,6'h00}, 4'hb},
    '{1'b0, 1'b1, 5'h0a, 12'h46e, 8'hc3, {6'h1e,6'h18,6'h14,6'h19}, 4'h0}};
  prd_word_src u_prd_word_src (.sync(s), .bad(b), .rat(rat), .lanes(ln),
    .halves(hv), .word(word), .plat_ok(plat_ok));
  prd_decode u_prd_decode (.clock(clock), .rst_n(rst_n), .ce(ce),
    .reset_config_word(word), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .cfg_valid(cfg_valid),
    .mem_ctrl0_cfg(mem0), .mem_ctrl1_cfg(mem1), .lane_cfg(lane),
    .cfg_error(cfg_error));
  // free running 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////
  // expected multiplier: async list, or the single sync code
  function automatic logic [4:0] exp_mult(input logic m, input logic [4:0] c);
    case (c)
      5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0c,
      5'h0d, 5'h10, 5'h12, 5'h13, 5'h14, 5'h18: exp_mult = m ? 5'h00 : c;
      5'h01: exp_mult = m ? c : 5'h00;
      default: exp_mult = 5'h00;
    endcase
  endfunction
  task test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_mem(input string n, input prd_pkg::prd_mem_cfg_t e,
    input prd_pkg::prd_mem_cfg_t g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_lane(input string n, input prd_pkg::prd_lane_cfg_t e);
    checked++;
    if (lane !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, lane);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  // one avalon access; request held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n == 20) begin
      err_total++;
      test_done();
    end
  endtask
  // bounded wait for the decoded settings
  task wait_valid();
    int n;
    for (n = 0; n < 20 && cfg_valid !== 1'b1; n++) @(posedge clock);
    if (n == 20) begin
      err_total++;
      test_done();
    end
  endtask
  // reset, capture, then check every output and register
  task run(input prd_row_t r);
    prd_pkg::prd_mem_cfg_t m;
    logic [5:0] e;
    logic [31:0] x [5];
    s <= r.s;
    b <= r.b;
    rat <= r.rat;
    ln <= r.ln;
    hv <= r.hv;
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    chk_w("valid in reset", 32'h0, {31'h0, cfg_valid});
    rst_n <= 1'b1;
    wait_valid();
    m = '{r.s, r.s, r.s, exp_mult(r.s, r.rat), (r.s || r.rat == 5'h08 ||
      r.rat == 5'h09 || r.rat == 5'h0a) ? 2'h1 : 2'h3};
    e = {r.b, m.mult == 5'h00, r.le};
    chk_mem("ctrl0", m, mem0);
    chk_mem("ctrl1", m, mem1);
    chk_lane("lanes", {r.mu, r.hv});
    chk_w("error", {31'h0, |e}, {31'h0, cfg_error});
    x = '{{22'h0, m}, {8'h0, r.mu}, {24'h0, r.hv[2:0], r.hv[7:3]},
      {26'h0, e}, {29'h0, 1'b0, r.s ^ r.b, r.s}};
    for (int k = 0; k < 5; k++) begin
      bus(1'b0, adr[k], 32'h0);
      chk_w("register", x[k], q);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    {read, write, s, b, rat, ln, hv, address, writedata} = '0;
    err_total = 0;
    checked = 0;
    adr = '{prd_pkg::REG_MEM, prd_pkg::REG_LANE, prd_pkg::REG_HALVE,
      prd_pkg::REG_ERR, prd_pkg::REG_MODE};
    foreach (rows[j]) run(rows[j]);
    chk_w("platform minimum", 32'h1, {31'h0, plat_ok});
    $display("test rows done");
    // every ratio code in both modes
    for (i = 0; i < 64; i++) begin
      rw = rows[0];
      rw.s = i[5];
      rw.rat = i[4:0];
      run(rw);
    end
    $display("test ratio sweep done");
    // pins moving after capture change nothing
    {s, ln, hv, rat} <= '0;
    repeat (4) @(posedge clock);
    chk_lane("held lanes", {rows[0].mu, rows[0].hv});
    chk_mem("held mem", 10'h381, mem0);
    $display("test hold done");
    // clear only the bits written as one, read-only and unmapped places
    bus(1'b1, prd_pkg::REG_ERR, 32'h0f);
    bus(1'b0, prd_pkg::REG_ERR, 32'h0);
    chk_w("err partial", 32'h10, q);
    bus(1'b1, prd_pkg::REG_ERR, 32'h10);
    bus(1'b0, prd_pkg::REG_ERR, 32'h0);
    chk_w("err cleared", 32'h0, {q[31:1], cfg_error});
    bus(1'b1, prd_pkg::REG_MEM, 32'hffffffff);
    bus(1'b0, prd_pkg::REG_MEM, 32'h0);
    chk_w("ro write", 32'h381, q);
    bus(1'b0, 8'h20, 32'h0);
    chk_w("unmapped", 32'h0, q);
    $display("test registers done");
    // clock enable low holds off the capture
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    ce <= 1'b0;
    repeat (8) @(posedge clock);
    chk_w("frozen", 32'h0, {31'h0, cfg_valid});
    ce <= 1'b1;
    wait_valid();
    $display("test enable done");
    test_done();
  end
endmodule
